// ===== rtl/loe_map.svh
// Constants for the logic-op execute unit: opcodes, cycle counts, flag bits, register map
`ifndef LOE_MAP_SVH
`define LOE_MAP_SVH

// ----------------------------------------------------------------------------
// Opcodes and reg-field selectors
// ----------------------------------------------------------------------------
`define LOE_OPC_IDLE 8'h90
`define LOE_OPC_GRP_BYTE 8'hf6
`define LOE_OPC_GRP_WORD 8'hf7
`define LOE_OPC_OR_ACC_BYTE 8'h0c
`define LOE_OPC_OR_ACC_WORD 8'h0d
`define LOE_OPC_OR_IMM_BYTE 8'h80
`define LOE_OPC_OR_IMM_WORD 8'h81
`define LOE_OPC_OR_IMM_SEXT 8'h83
`define LOE_OPC_OR_RM_REG_BYTE 8'h08
`define LOE_OPC_OR_RM_REG_WORD 8'h09
`define LOE_OPC_OR_REG_RM_BYTE 8'h0a
`define LOE_OPC_OR_REG_RM_WORD 8'h0b
`define LOE_REGF_NOT 3'h2
`define LOE_REGF_OR 3'h1

// ----------------------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------------------
`define LOE_CYC_IDLE 5'h03
`define LOE_CYC_NOT_REG 5'h03
`define LOE_CYC_NOT_MEM 5'h0a
`define LOE_CYC_NOT_MEM_NARROW 5'h0e
`define LOE_CYC_OR_ACC_BYTE 5'h03
`define LOE_CYC_OR_ACC_WORD 5'h04
`define LOE_CYC_OR_IMM_REG 5'h04
`define LOE_CYC_OR_IMM_MEM 5'h10
`define LOE_CYC_OR_IMM_MEM_NARROW 5'h14
`define LOE_CYC_OR_R_REG 5'h03
`define LOE_CYC_OR_R_MEM 5'h0a
`define LOE_CYC_OR_R_MEM_NARROW 5'h0e

// ----------------------------------------------------------------------------
// Status flag bit positions and masks
// ----------------------------------------------------------------------------
`define LOE_FLAG_CARRY 0
`define LOE_FLAG_PARITY 2
`define LOE_FLAG_AUX 4
`define LOE_FLAG_ZERO 6
`define LOE_FLAG_SIGN 7
`define LOE_FLAG_OVERFLOW 11
`define LOE_FLAGS_WMASK 16'h0fd5
`define LOE_FLAGS_RESET 16'h0000

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define LOE_ADDR_FLAGS 4'h0
`define LOE_ADDR_CTRL 4'h1
`define LOE_ADDR_STATUS 4'h2
`define LOE_CTRL_NARROW 0
`define LOE_CTRL_RESET 1'b0
`define LOE_STAT_BUSY 0
`define LOE_STAT_ILLEGAL 1

`endif

// ===== rtl/loe_pkg.sv
// Types shared by the logic-op execute unit
package loe_pkg;
  typedef logic [15:0] loe_word_type;
  typedef logic [3:0] loe_addr_type;

  typedef enum logic [1:0] {
    LOE_OP_IDLE = 2'b00,
    LOE_OP_NOT = 2'b01,
    LOE_OP_OR = 2'b10
  } loe_op_type;

  typedef enum logic [0:0] {
    LOE_ST_IDLE = 1'b0,
    LOE_ST_RUN = 1'b1
  } loe_state_type;

  typedef struct packed {
    logic valid;
    loe_op_type op;
    logic word;
    logic use_src;
    logic use_imm;
    logic sext;
    logic write;
    logic [4:0] cycles;
  } loe_decode_type;
endpackage

// ===== rtl/loe_alu_if.sv
// Operand and result bundle between the execute sequencer and its ALU
`timescale 1ns/1ps
`default_nettype none
interface loe_alu_if;
  import loe_pkg::*;
  loe_op_type op;
  logic word;
  loe_word_type a;
  loe_word_type b;
  loe_word_type result;
  logic sign;
  logic zero;
  logic parity;
  modport core (output op, output word, output a, output b,
                input result, input sign, input zero, input parity);
  modport alu (input op, input word, input a, input b,
               output result, output sign, output zero, output parity);
endinterface
`default_nettype wire

// ===== rtl/loe_alu.sv
// Combinational complement / inclusive-OR datapath with flag terms
`timescale 1ns/1ps
`default_nettype none
module loe_alu (
  loe_alu_if.alu port
);
  import loe_pkg::*;

  loe_word_type raw;

  always_comb begin
    case (port.op)
      LOE_OP_NOT: raw = port.a ^ 16'hffff;
      LOE_OP_OR: raw = port.a | port.b;
      default: raw = port.a;
    endcase
  end

  // Byte forms return a clean low byte so the upper half never leaks
  assign port.result = port.word ? raw : {8'h00, raw[7:0]};
  assign port.sign = port.word ? raw[15] : raw[7];
  assign port.zero = port.word ? (raw == 16'h0000) : (raw[7:0] == 8'h00);
  assign port.parity = ~^raw[7:0];
endmodule // loe_alu
`default_nettype wire

// ===== rtl/loe_exec.sv
// Execute unit for the idle, complement and inclusive-OR instructions
//
// Functional notes
// - Opcode 90 decodes as a one-byte idle instruction without operands.
// - Idle instruction changes no register, memory or flag; only IP advances.
// - Idle instruction takes 3 cycles on both bus widths.
// - F6 /2 byte complement takes 3 register or 10 memory cycles.
// - F7 /2 word complement takes 3/10, or 3/14 on narrow bus.
// - Complement inverts every operand bit and writes it back.
// - Complement equals XOR with all ones but leaves flags unchanged.
// - 0C/0D OR immediate into accumulator byte/word in 3/4 cycles.
// - 80/81 /1 OR immediate into r/m: 4 register, 16 or 20 memory.
// - 83 /1 OR byte immediate into r/m word: 4, 16 or 20.
// - 08/09 OR register into r/m: 3 register, 10 or 14 memory.
// - 0A/0B OR r/m into register with same cycle costs.
// - OR writes first operand; bit is zero only if both are zero.
// - Every OR form clears overflow and carry flags.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "loe_map.svh"
module loe_exec (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [2:0] reg_field,
  input wire logic mem_operand,
  input wire loe_pkg::loe_word_type dst_value,
  input wire loe_pkg::loe_word_type src_value,
  input wire loe_pkg::loe_word_type imm_value,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic writeback,
  output logic word_result,
  output loe_pkg::loe_word_type result,
  output loe_pkg::loe_word_type flags,
  input wire loe_pkg::loe_addr_type bus_addr,
  input wire loe_pkg::loe_word_type bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output loe_pkg::loe_word_type bus_rdata
);
  import loe_pkg::*;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  function automatic logic [4:0] pick_cycles(input logic mem, input logic narrow_word,
                                             input logic [4:0] reg_cyc,
                                             input logic [4:0] mem_cyc,
                                             input logic [4:0] narrow_cyc);
    logic [4:0] c;
    if (!mem) begin
      c = reg_cyc;
    end else if (narrow_word) begin
      c = narrow_cyc;
    end else begin
      c = mem_cyc;
    end
    return c;
  endfunction

  function automatic loe_decode_type decode(input logic [7:0] opc, input logic [2:0] regf,
                                            input logic mem, input logic narrow);
    loe_decode_type d;
    d = '0;
    d.op = LOE_OP_IDLE;
    d.valid = 1'b1;
    d.write = 1'b1;
    case (opc)
      `LOE_OPC_IDLE: begin
        d.word = 1'b1;
        d.write = 1'b0;
        d.cycles = `LOE_CYC_IDLE;
      end
      `LOE_OPC_GRP_BYTE, `LOE_OPC_GRP_WORD: begin
        d.valid = (regf == `LOE_REGF_NOT);
        d.op = LOE_OP_NOT;
        d.word = opc[0];
        d.cycles = pick_cycles(mem, narrow & opc[0], `LOE_CYC_NOT_REG,
                               `LOE_CYC_NOT_MEM, `LOE_CYC_NOT_MEM_NARROW);
      end
      `LOE_OPC_OR_ACC_BYTE, `LOE_OPC_OR_ACC_WORD: begin
        d.op = LOE_OP_OR;
        d.word = opc[0];
        d.use_imm = 1'b1;
        d.cycles = opc[0] ? `LOE_CYC_OR_ACC_WORD : `LOE_CYC_OR_ACC_BYTE;
      end
      `LOE_OPC_OR_IMM_BYTE, `LOE_OPC_OR_IMM_WORD, `LOE_OPC_OR_IMM_SEXT: begin
        d.valid = (regf == `LOE_REGF_OR);
        d.op = LOE_OP_OR;
        d.word = opc[0] | opc[1];
        d.use_imm = 1'b1;
        d.sext = opc[1];
        d.cycles = pick_cycles(mem, narrow & d.word, `LOE_CYC_OR_IMM_REG,
                               `LOE_CYC_OR_IMM_MEM, `LOE_CYC_OR_IMM_MEM_NARROW);
      end
      `LOE_OPC_OR_RM_REG_BYTE, `LOE_OPC_OR_RM_REG_WORD,
      `LOE_OPC_OR_REG_RM_BYTE, `LOE_OPC_OR_REG_RM_WORD: begin
        d.op = LOE_OP_OR;
        d.word = opc[0];
        d.use_src = 1'b1;
        d.cycles = pick_cycles(mem, narrow & opc[0], `LOE_CYC_OR_R_REG,
                               `LOE_CYC_OR_R_MEM, `LOE_CYC_OR_R_MEM_NARROW);
      end
      default: begin
        d.valid = 1'b0;
      end
    endcase
    return d;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  loe_state_type state_reg;
  loe_op_type op_reg;
  logic word_reg;
  logic write_reg;
  logic [4:0] count_reg;
  loe_word_type a_reg;
  loe_word_type b_reg;
  logic narrow_reg;
  logic illegal_seen_reg;
  loe_word_type flags_reg;
  loe_word_type flags_next;
  loe_word_type rdata_reg;
  logic done_reg;
  logic illegal_reg;
  logic writeback_reg;
  loe_word_type result_reg;
  loe_decode_type dec;
  logic accept;
  logic finish;

  loe_alu_if alu_bus ();
  loe_alu alu_inst (
    .port(alu_bus.alu)
  );

  assign alu_bus.op = op_reg;
  assign alu_bus.word = word_reg;
  assign alu_bus.a = a_reg;
  assign alu_bus.b = b_reg;

  assign dec = decode(opcode, reg_field, mem_operand, narrow_reg);
  // A start while a previous instruction runs is ignored, not queued
  assign accept = start && (state_reg == LOE_ST_IDLE);
  assign finish = (state_reg == LOE_ST_RUN) && (count_reg == 5'h00);

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= LOE_ST_IDLE;
      count_reg <= 5'h00;
    end else if (clock_enable) begin
      case (state_reg)
        LOE_ST_IDLE: begin
          if (accept && dec.valid) begin
            state_reg <= LOE_ST_RUN;
            count_reg <= dec.cycles - 5'h01;
          end
        end
        LOE_ST_RUN: begin
          if (count_reg == 5'h00) begin
            state_reg <= LOE_ST_IDLE;
          end else begin
            count_reg <= count_reg - 5'h01;
          end
        end
        default: begin
          state_reg <= LOE_ST_IDLE;
        end
      endcase
    end
  end

  // Operands are captured at start so the decoder may move on at once
  always_ff @(posedge clock) begin
    if (reset) begin
      op_reg <= LOE_OP_IDLE;
      word_reg <= 1'b0;
      write_reg <= 1'b0;
      a_reg <= 16'h0000;
      b_reg <= 16'h0000;
    end else if (clock_enable && accept && dec.valid) begin
      op_reg <= dec.op;
      word_reg <= dec.word;
      write_reg <= dec.write;
      a_reg <= dst_value;
      if (dec.use_src) begin
        b_reg <= src_value;
      end else if (dec.sext) begin
        b_reg <= {{8{imm_value[7]}}, imm_value[7:0]};
      end else if (dec.use_imm && !dec.word) begin
        b_reg <= {8'h00, imm_value[7:0]};
      end else begin
        b_reg <= imm_value;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Completion outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      writeback_reg <= 1'b0;
      result_reg <= 16'h0000;
    end else if (clock_enable) begin
      done_reg <= finish;
      illegal_reg <= accept && !dec.valid;
      writeback_reg <= finish && write_reg;
      if (finish) begin
        result_reg <= alu_bus.result;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Flags: hardware update wins over a software write in the same cycle
  // --------------------------------------------------------------------------
  always_comb begin
    flags_next = flags_reg;
    if (bus_write && (bus_addr == `LOE_ADDR_FLAGS)) begin
      flags_next = bus_wdata & `LOE_FLAGS_WMASK;
    end
    // Complement and idle leave every flag alone
    if (finish && (op_reg == LOE_OP_OR)) begin
      flags_next[`LOE_FLAG_OVERFLOW] = 1'b0;
      flags_next[`LOE_FLAG_CARRY] = 1'b0;
      flags_next[`LOE_FLAG_SIGN] = alu_bus.sign;
      flags_next[`LOE_FLAG_ZERO] = alu_bus.zero;
      flags_next[`LOE_FLAG_PARITY] = alu_bus.parity;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      flags_reg <= `LOE_FLAGS_RESET;
    end else if (clock_enable) begin
      flags_reg <= flags_next;
    end
  end

  // --------------------------------------------------------------------------
  // Control and status registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      narrow_reg <= `LOE_CTRL_RESET;
    end else if (clock_enable && bus_write && (bus_addr == `LOE_ADDR_CTRL)) begin
      narrow_reg <= bus_wdata[`LOE_CTRL_NARROW];
    end
  end

  // Sticky; write one to clear, a new event in the same cycle wins
  always_ff @(posedge clock) begin
    if (reset) begin
      illegal_seen_reg <= 1'b0;
    end else if (clock_enable) begin
      if (accept && !dec.valid) begin
        illegal_seen_reg <= 1'b1;
      end else if (bus_write && (bus_addr == `LOE_ADDR_STATUS)
                   && bus_wdata[`LOE_STAT_ILLEGAL]) begin
        illegal_seen_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else if (clock_enable) begin
      if (!bus_read) begin
        rdata_reg <= 16'h0000;
      end else if (bus_addr == `LOE_ADDR_FLAGS) begin
        rdata_reg <= flags_reg;
      end else if (bus_addr == `LOE_ADDR_CTRL) begin
        rdata_reg <= {15'h0000, narrow_reg};
      end else if (bus_addr == `LOE_ADDR_STATUS) begin
        rdata_reg <= {14'h0000, illegal_seen_reg, state_reg == LOE_ST_RUN};
      end else begin
        rdata_reg <= 16'h0000;
      end
    end
  end

  assign busy = (state_reg == LOE_ST_RUN);
  assign done = done_reg;
  assign illegal = illegal_reg;
  assign writeback = writeback_reg;
  assign word_result = word_reg;
  assign result = result_reg;
  assign flags = flags_reg;
  assign bus_rdata = rdata_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic go;
  assign go = accept && dec.valid && clock_enable;

  AST_IDLE_THREE: assert property (@(posedge clock) disable iff (reset || !clock_enable)
    go && (opcode == `LOE_OPC_IDLE) |-> ##4 done_reg)
    else $error("idle instruction did not finish in 3 cycles");
  AST_IDLE_NO_EFFECT: assert property (@(posedge clock) disable iff (reset)
    done_reg && (op_reg == LOE_OP_IDLE) && !$past(bus_write)
      |-> !writeback_reg && (flags_reg == $past(flags_reg)))
    else $error("idle instruction touched state");
  AST_NOT_BYTE_MEM: assert property (@(posedge clock) disable iff (reset || !clock_enable)
    go && (opcode == `LOE_OPC_GRP_BYTE) && mem_operand |-> ##11 done_reg)
    else $error("byte complement memory count wrong");
  AST_NOT_WORD_NARROW: assert property (@(posedge clock) disable iff (reset || !clock_enable)
    go && (opcode == `LOE_OPC_GRP_WORD) && mem_operand && narrow_reg |-> ##15 done_reg)
    else $error("narrow word complement count wrong");
  AST_NOT_VALUE: assert property (@(posedge clock) disable iff (reset)
    done_reg && (op_reg == LOE_OP_NOT) && word_reg |-> writeback_reg && (result_reg == ~a_reg))
    else $error("complement result wrong");
  AST_NOT_FLAGS: assert property (@(posedge clock) disable iff (reset)
    done_reg && (op_reg == LOE_OP_NOT) && !$past(bus_write) |-> $stable(flags_reg))
    else $error("complement changed flags");
  AST_OR_ACC: assert property (@(posedge clock) disable iff (reset || !clock_enable)
    go && (opcode == `LOE_OPC_OR_ACC_WORD) |-> ##1 !done_reg[*4] ##1 done_reg)
    else $error("accumulator OR count wrong");
  AST_OR_IMM_NARROW: assert property (@(posedge clock) disable iff (reset || !clock_enable)
    go && (opcode == `LOE_OPC_OR_IMM_WORD) && mem_operand && narrow_reg |-> ##21 done_reg)
    else $error("word immediate OR count wrong");
  AST_OR_SEXT_REG: assert property (@(posedge clock) disable iff (reset || !clock_enable)
    go && (opcode == `LOE_OPC_OR_IMM_SEXT) && !mem_operand |-> ##5 done_reg)
    else $error("sign-extended OR count wrong");
  AST_OR_REG_MEM: assert property (@(posedge clock) disable iff (reset || !clock_enable)
    go && (opcode == `LOE_OPC_OR_RM_REG_WORD) && mem_operand && narrow_reg |-> ##15 done_reg)
    else $error("register to memory OR count wrong");
  AST_OR_MEM_REG: assert property (@(posedge clock) disable iff (reset || !clock_enable)
    go && (opcode == `LOE_OPC_OR_REG_RM_BYTE) && mem_operand |-> ##11 done_reg)
    else $error("memory to register OR count wrong");
  AST_OR_VALUE: assert property (@(posedge clock) disable iff (reset)
    done_reg && (op_reg == LOE_OP_OR) && word_reg |-> result_reg == (a_reg | b_reg))
    else $error("OR result wrong");
  AST_OR_CLEARS: assert property (@(posedge clock) disable iff (reset)
    done_reg && (op_reg == LOE_OP_OR)
      |-> !flags_reg[`LOE_FLAG_OVERFLOW] && !flags_reg[`LOE_FLAG_CARRY])
    else $error("OR left overflow or carry set");
  AST_SEXT: assert property (@(posedge clock) disable iff (reset || !clock_enable)
    go && (opcode == `LOE_OPC_OR_IMM_SEXT) |=> b_reg == {{8{$past(imm_value[7])}},
                                                         $past(imm_value[7:0])})
    else $error("immediate not sign-extended");
  AST_OR_ZERO: assert property (@(posedge clock) disable iff (reset)
    done_reg && (op_reg == LOE_OP_OR) && word_reg
      |-> flags_reg[`LOE_FLAG_ZERO] == (result_reg == 16'h0000))
    else $error("zero flag wrong after OR");

  COV_IDLE: cover property (@(posedge clock) done_reg && (op_reg == LOE_OP_IDLE));
  COV_NOT: cover property (@(posedge clock) done_reg && (op_reg == LOE_OP_NOT));
  COV_OR: cover property (@(posedge clock) done_reg && (op_reg == LOE_OP_OR));
  COV_ILLEGAL: cover property (@(posedge clock) illegal_reg);
endmodule // loe_exec
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the logic-op execute unit
`timescale 1ns/1ps
`default_nettype none
`include "loe_map.svh"
module tb_top;
  import loe_pkg::*;
  logic clock;
  logic reset;
  logic clock_enable;
  logic start;
  logic [7:0] opcode;
  logic [2:0] reg_field;
  logic mem_operand;
  loe_word_type dst_value, src_value, imm_value, result, flags, bus_wdata, bus_rdata;
  logic busy, done, illegal, writeback, word_result, bus_write, bus_read, ctl_nw;
  loe_addr_type bus_addr;
  loe_word_type rd, flm, va, vs, vi;
  logic [2:0] rf;
  logic [31:0] rng;
  int fails, checks;
  logic [7:0] tab [12] = '{8'h90, 8'hf6, 8'hf7, 8'h0c, 8'h0d, 8'h80, 8'h81, 8'h83,
                            8'h08, 8'h09, 8'h0a, 8'h0b};

  loe_exec i_dut (.clock(clock), .reset(reset), .clock_enable(clock_enable), .start(start),
    .opcode(opcode), .reg_field(reg_field), .mem_operand(mem_operand), .dst_value(dst_value),
    .src_value(src_value), .imm_value(imm_value), .busy(busy), .done(done), .illegal(illegal),
    .writeback(writeback), .word_result(word_result), .result(result), .flags(flags),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
    .bus_rdata(bus_rdata));

  // ---------------------------------------------------------------------------
  // Expectations
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  function automatic int exp_cyc(input logic [7:0] o, input logic m, input logic nw);
    case (o)
      8'h90, 8'h0c: return 3;
      8'h0d: return 4;
      8'hf6, 8'h08, 8'h0a: return m ? 10 : 3;
      8'hf7, 8'h09, 8'h0b: return m ? (nw ? 14 : 10) : 3;
      8'h80: return m ? 16 : 4;
      default: return m ? (nw ? 20 : 16) : 4;
    endcase
  endfunction

  function automatic loe_word_type exp_res(input logic [7:0] o, input loe_word_type a,
                                           input loe_word_type s, input loe_word_type i);
    loe_word_type b;
    loe_word_type r;
    case (o)
      8'h0c, 8'h0d, 8'h80, 8'h81: b = i;
      8'h83: b = {{8{i[7]}}, i[7:0]};
      default: b = s;
    endcase
    r = (o[7:4] == 4'hf) ? ~a : (a | b);
    return o[0] ? r : {8'h00, r[7:0]};
  endfunction

  // Aux carry is kept: leaving it alone is one legal reading of undefined
  function automatic loe_word_type exp_flags(input logic [7:0] o, input loe_word_type r,
                                             input loe_word_type f);
    loe_word_type g;
    g = f;
    // Both the 0x and the 8x opcode rows are OR forms
    if ((o[7:4] == 4'h0) || (o[7:4] == 4'h8)) begin
      g[0] = 1'b0;
      g[11] = 1'b0;
      g[7] = o[0] ? r[15] : r[7];
      g[6] = (r == 16'h0000);
      g[2] = ~^r[7:0];
    end
    return g;
  endfunction

  // ---------------------------------------------------------------------------
  // Compare, bus and instruction tasks
  // ---------------------------------------------------------------------------
  task automatic chk_word(input loe_word_type got, input loe_word_type exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bwr(input loe_addr_type a, input loe_word_type d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask

  task automatic brd(input loe_addr_type a);
    @(posedge clock);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    @(negedge clock);
    rd = bus_rdata;
  endtask

  task automatic run_op(input logic [7:0] o, input logic [2:0] f, input logic m,
                        input loe_word_type a, input loe_word_type s, input loe_word_type i);
    int n;
    logic ill;
    loe_word_type er;
    n = 0;
    ill = 1'b0;
    er = exp_res(o, a, s, i);
    @(posedge clock);
    start <= 1'b1;
    opcode <= o;
    reg_field <= f;
    mem_operand <= m;
    dst_value <= a;
    src_value <= s;
    imm_value <= i;
    @(posedge clock);
    start <= 1'b0;
    do begin
      @(negedge clock);
      n++;
      ill = ill | (illegal === 1'b1);
    end while (done !== 1'b1 && n < 40);
    // Done follows the last busy cycle, so n holds one more than the cost
    chk_cnt(n - 1, exp_cyc(o, m, ctl_nw));
    chk_word({15'h0000, ill}, 16'h0000);
    chk_word({15'h0000, writeback}, {15'h0000, o != 8'h90});
    if (o != 8'h90) begin
      chk_word(result, er);
      chk_word({15'h0000, word_result}, {15'h0000, o[0]});
    end
    flm = exp_flags(o, er, flm);
    chk_word(flags, flm);
  endtask

  task automatic print_verdict;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // About 50 instructions of at most 20 cycles each fit well inside this span
  initial begin
    #200000;
    fails++;
    print_verdict;
  end

  initial begin
    reset = 1'b1;
    clock_enable = 1'b1;
    start = 1'b0;
    opcode = 8'h00;
    reg_field = 3'h0;
    mem_operand = 1'b0;
    dst_value = 16'h0000;
    src_value = 16'h0000;
    imm_value = 16'h0000;
    bus_addr = 4'h0;
    bus_wdata = 16'h0000;
    bus_write = 1'b0;
    bus_read = 1'b0;
    fails = 0;
    checks = 0;
    rng = 32'h00000035;
    flm = 16'h0000;
    ctl_nw = 1'b0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk_word(flags, 16'h0000);
    chk_word(result, 16'h0000);
    chk_word({bus_rdata[14:0], busy}, 16'h0000);
    brd(`LOE_ADDR_CTRL);
    chk_word(rd, 16'h0000);
    bwr(`LOE_ADDR_FLAGS, 16'hffff);
    brd(`LOE_ADDR_FLAGS);
    chk_word(rd, `LOE_FLAGS_WMASK);
    flm = `LOE_FLAGS_WMASK;
    bwr(4'h7, 16'h1234);
    brd(4'h7);
    chk_word(rd, 16'h0000);
    run_op(8'h83, 3'h1, 1'b0, 16'h0001, 16'h0000, 16'h0080);
    run_op(8'h0c, 3'h0, 1'b0, 16'hff00, 16'h0000, 16'hff00);
    run_op(8'hf7, 3'h2, 1'b0, 16'hffff, 16'h0000, 16'h0000);
    for (int nw = 0; nw < 2; nw++) begin
      bwr(`LOE_ADDR_CTRL, {15'h0000, nw[0]});
      ctl_nw = nw[0];
      for (int k = 0; k < 12; k++) begin
        for (int m = 0; m < 2; m++) begin
          rng = xs(rng);
          va = rng[15:0];
          vs = rng[31:16];
          rng = xs(rng);
          vi = rng[15:0];
          bwr(`LOE_ADDR_FLAGS, rng[31:16]);
          flm = rng[31:16] & `LOE_FLAGS_WMASK;
          rf = (tab[k][7:4] == 4'hf) ? 3'h2 : (tab[k][7:4] == 4'h8) ? 3'h1 : rng[18:16];
          run_op(tab[k], rf, m[0], va, vs, vi);
        end
      end
    end
    // A flag write while the clock enable is low must be lost
    @(posedge clock);
    clock_enable <= 1'b0;
    bwr(`LOE_ADDR_FLAGS, ~flm);
    clock_enable <= 1'b1;
    brd(`LOE_ADDR_FLAGS);
    chk_word(rd, flm);
    @(posedge clock);
    start <= 1'b1;
    opcode <= 8'hf6;
    reg_field <= 3'h3;
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    chk_word({15'h0000, illegal}, 16'h0001);
    brd(`LOE_ADDR_STATUS);
    chk_word(rd, 16'h0002);
    bwr(`LOE_ADDR_STATUS, 16'h0002);
    brd(`LOE_ADDR_STATUS);
    chk_word(rd, 16'h0000);
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
